// ===== eipb_pkg.sv
// Purpose: Constants for the extended interrupt priority bank
// Assumes: Special-function register space with byte-wide data
// Notes:   Bit positions follow the priority register layout
`default_nettype none
package eipb_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] EIPB_PRIO1_ADDR = 8'hf6;
    localparam logic [7:0] EIPB_PRIO1_RESET = 8'h00;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int EIPB_BIT_TIMER3 = 7;
    localparam int EIPB_BIT_CMP1 = 6;
    localparam int EIPB_BIT_CMP0 = 5;
    localparam int EIPB_BIT_PCA = 4;
    localparam int EIPB_BIT_ADCDONE = 3;
    localparam int EIPB_BIT_ADCWIN = 2;
    localparam int EIPB_BIT_RTC = 1;
    localparam int EIPB_BIT_TWOWIRE = 0;
endpackage : eipb_pkg
`default_nettype wire

// ===== eipb_priority_bank.sv
// Purpose: Priority register for eight extended interrupt sources
// Assumes: Core special-function bus, single clock, synchronous reset
// Notes:   Levels move on the same edge as the register
// Function
// - Bit 7 sets timer three level
// - Bit 6 sets comparator one level
// - Bit 5 sets comparator zero level
// - Bit 4 sets counter array level
// - Bit 3 sets conversion-complete level
// - Bit 2 sets window-compare level
// - Bit 1 sets real-time clock level
// - Bit 0 sets two-wire port level
`timescale 1ns/100ps
`default_nettype none
module eipb_priority_bank
    import eipb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Special-function register access
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    // Priority levels to the core, 1 = high
    output logic timer_three_priority,
    output logic cmp1_priority,
    output logic cmp0_priority,
    output logic counter_array_priority,
    output logic adc_done_priority,
    output logic adc_window_priority,
    output logic rtc_priority,
    output logic twowire_priority
);
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Full eight-bit compare; no aliasing onto neighbouring registers
    function automatic logic eipb_hit(input logic [7:0] addr);
        eipb_hit = (addr == EIPB_PRIO1_ADDR);
    endfunction : eipb_hit

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [7:0] prio_r;
    logic [7:0] prio_nxt;
    logic [7:0] rdata_nxt;
    wire hitPrio = eipb_hit(sfrAddr);
    wire wrPrio = sfrWrite && hitPrio;
    wire rdPrio = sfrRead && hitPrio;
    // Write replaces all eight levels at once
    assign prio_nxt = wrPrio ? sfrWdata : prio_r;
    // Unmapped reads return zero so other banks can be ORed in
    // A read in the write cycle returns the old value
    assign rdata_nxt = rdPrio ? prio_r : 8'h00;

    // ----------------------------------------
    // Register and read data
    // ----------------------------------------
    // all bits stored
    // same register
    // Reset clears the read port too, so no stale byte follows it
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            prio_r <= EIPB_PRIO1_RESET;
            sfrRdata <= 8'h00;
        end
        else
        begin
            prio_r <= prio_nxt;
            sfrRdata <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Priority outputs
    // ----------------------------------------
    // flopped copy of levels
    // Flopped from prio_nxt so outputs come straight from flops
    // and move on the same edge as the register, adding no delay
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            // Reset levels taken bit by bit from the register reset value
            timer_three_priority <= EIPB_PRIO1_RESET[EIPB_BIT_TIMER3];
            cmp1_priority <= EIPB_PRIO1_RESET[EIPB_BIT_CMP1];
            cmp0_priority <= EIPB_PRIO1_RESET[EIPB_BIT_CMP0];
            counter_array_priority <= EIPB_PRIO1_RESET[EIPB_BIT_PCA];
            adc_done_priority <= EIPB_PRIO1_RESET[EIPB_BIT_ADCDONE];
            adc_window_priority <= EIPB_PRIO1_RESET[EIPB_BIT_ADCWIN];
            rtc_priority <= EIPB_PRIO1_RESET[EIPB_BIT_RTC];
            twowire_priority <= EIPB_PRIO1_RESET[EIPB_BIT_TWOWIRE];
        end
        else
        begin
            timer_three_priority <= prio_nxt[EIPB_BIT_TIMER3];
            cmp1_priority <= prio_nxt[EIPB_BIT_CMP1];
            cmp0_priority <= prio_nxt[EIPB_BIT_CMP0];
            counter_array_priority <= prio_nxt[EIPB_BIT_PCA];
            adc_done_priority <= prio_nxt[EIPB_BIT_ADCDONE];
            adc_window_priority <= prio_nxt[EIPB_BIT_ADCWIN];
            rtc_priority <= prio_nxt[EIPB_BIT_RTC];
            twowire_priority <= prio_nxt[EIPB_BIT_TWOWIRE];
        end
    end

    // ----------------------------------------
    // Check helpers
    // ----------------------------------------
    // Levels as the core sees them, bit order matches the register
    wire [7:0] levelBus = {
        timer_three_priority,
        cmp1_priority,
        cmp0_priority,
        counter_array_priority,
        adc_done_priority,
        adc_window_priority,
        rtc_priority,
        twowire_priority
    };

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    // Write taken at this edge
    sequence s_wr;
        sfrWrite && hitPrio;
    endsequence
    // Read taken at this edge, no write beside it
    sequence s_rd;
        rdPrio && !wrPrio;
    endsequence
    // Read and write taken at the same edge
    sequence s_rd_wr;
        rdPrio && wrPrio;
    endsequence
    // Two edges in a row with no write
    sequence s_quiet;
        !wrPrio ##1 !wrPrio;
    endsequence
    // Write, then a plain read at the next edge
    sequence s_wr_rd;
        s_wr ##1 s_rd;
    endsequence

    // ----------------------------------------
    // Per-source checks
    // ----------------------------------------
    AST_T3: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> timer_three_priority == $past(sfrWdata[7]))
        else $error("timer three level wrong");
    AST_C1: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> cmp1_priority == $past(sfrWdata[6]))
        else $error("comparator one level wrong");
    AST_C0: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> cmp0_priority == $past(sfrWdata[5]))
        else $error("comparator zero level wrong");
    AST_PCA: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> counter_array_priority == $past(sfrWdata[4]))
        else $error("counter array level wrong");
    AST_ADC: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> adc_done_priority == $past(sfrWdata[3]))
        else $error("conversion level wrong");
    AST_WIN: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> adc_window_priority == $past(sfrWdata[2]))
        else $error("window level wrong");
    AST_RTC: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> rtc_priority == $past(sfrWdata[1]))
        else $error("clock level wrong");
    AST_TW: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr |=> twowire_priority == $past(sfrWdata[0]))
        else $error("two-wire level wrong");

    // ----------------------------------------
    // Hold and readback checks
    // ----------------------------------------
    AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_quiet |=> $stable(levelBus))
        else $error("level moved without write");
    // Writes to other addresses must leave every level alone
    AST_UNMAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sfrWrite && !hitPrio) |=> $stable(levelBus))
        else $error("level moved on unmapped write");
    AST_RD: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_wr_rd |=> sfrRdata == $past(sfrWdata, 2))
        else $error("readback mismatch");
    // Software reads back exactly what the core is given
    AST_RDLVL: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_rd |=> sfrRdata == $past(levelBus))
        else $error("readback differs from levels");
    // Read beside a write returns the levels before the write
    AST_RDOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_rd_wr |=> sfrRdata == $past(levelBus))
        else $error("same-cycle read not old value");
    // Read port idles at zero so banks can be ORed together
    AST_RDZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rdPrio |=> sfrRdata == 8'h00)
        else $error("read data not zero when idle");

    // ----------------------------------------
    // Reset checks
    // ----------------------------------------
    // Reset wins over any strobe in the same cycle
    AST_RST: assert property (@(posedge core_clk)
        !rst_n |=> levelBus == EIPB_PRIO1_RESET && sfrRdata == 8'h00)
        else $error("reset left a level or read data set");
endmodule : eipb_priority_bank
`default_nettype wire

// ===== extended_interrupt_priority_bank_bench.sv
// Purpose: Self-checking bench for the priority bank
// Assumes: Inputs driven on the falling edge, 25 ns clock
// Notes:   Strobes re-driven by every acc call, held between calls
`timescale 1ns/100ps
`default_nettype none
module extended_interrupt_priority_bank_bench;
    import eipb_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic [7:0] sfrWdata = 8'h00;
    logic [7:0] sfrRdata;
    wire [7:0] prio;
    logic [7:0] got;
    logic [7:0] val;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    // ----
    // Clock and hang guard, test needs under 100 cycles
    // ----
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    eipb_priority_bank dut (.core_clk(core_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .timer_three_priority(prio[7]),
        .cmp1_priority(prio[6]), .cmp0_priority(prio[5]), .counter_array_priority(prio[4]),
        .adc_done_priority(prio[3]), .adc_window_priority(prio[2]), .rtc_priority(prio[1]),
        .twowire_priority(prio[0]));
    // One compare for all byte results
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // One cycle of access; caller sits on a falling edge
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        sfrWrite = w;
        sfrRead = r;
        sfrAddr = a;
        sfrWdata = d;
        @(negedge core_clk);
        got = sfrRdata;
    endtask : acc
    task automatic tally_and_finish();
        $display("Errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        chk(prio, EIPB_PRIO1_RESET, "reset levels");
        acc(1'b0, 1'b1, EIPB_PRIO1_ADDR, 8'h00);
        chk(got, EIPB_PRIO1_RESET, "reset value");
        // Walking one then walking zero, back to back
        for (int i = 0; i < 16; i++)
        begin
            val = (i < 8) ? (8'h01 << i) : ~(8'h01 << (i - 8));
            acc(1'b1, 1'b0, EIPB_PRIO1_ADDR, val);
            chk(prio, val, "levels");
            acc(1'b0, 1'b1, EIPB_PRIO1_ADDR, 8'h00);
            chk(got, val, "readback");
        end
        acc(1'b1, 1'b1, EIPB_PRIO1_ADDR, 8'h3c);
        chk(got, 8'h7f, "same-cycle read old");
        acc(1'b1, 1'b0, 8'hf7, 8'hff);
        chk(prio, 8'h3c, "unmapped write");
        acc(1'b0, 1'b1, 8'hf7, 8'h00);
        chk(got, 8'h00, "unmapped read");
        acc(1'b0, 1'b0, EIPB_PRIO1_ADDR, 8'h00);
        repeat (4) @(negedge core_clk);
        chk(prio, 8'h3c, "levels held");
        chk(sfrRdata, 8'h00, "read data idle");
        // Mid-run reset with a write pending: reset must win
        rst_n = 1'b0;
        acc(1'b1, 1'b0, EIPB_PRIO1_ADDR, 8'hff);
        chk(prio, 8'h00, "second reset");
        rst_n = 1'b1;
        acc(1'b0, 1'b1, EIPB_PRIO1_ADDR, 8'h00);
        chk(got, EIPB_PRIO1_RESET, "register after reset");
        acc(1'b1, 1'b0, EIPB_PRIO1_ADDR, 8'h81);
        chk(prio, 8'h81, "first write after reset");
        tally_and_finish();
    end
endmodule : extended_interrupt_priority_bank_bench
`default_nettype wire
